// ===== dv/mld_motor_model.sv
// Hall sensor and lock-timer capacitor model on the far side of the drive block
`timescale 1ns/100ps
module mld_motor_model (
  // Clock and rotor control from the bench
  input wire logic core_clk_i,
  input wire logic spin_i,
  input wire logic rev_i,
  // Sensor and timer pins
  output mld_pkg::mld_phase_t hall_o,
  output logic tick_o
);
  import mld_pkg::*;
  localparam mld_phase_t SEQ [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  int idx = 0;
  int cnt = 0;
  // Capacitor ticks every 4 cycles; rotor steps one sector every 40 cycles
  always @(posedge core_clk_i) begin
    cnt <= (cnt + 1) % 40;
    tick_o <= cnt[1];
    if (spin_i && cnt == 0) begin
      idx <= rev_i ? (idx + 5) % 6 : (idx + 1) % 6;
    end
  end
  assign hall_o = SEQ[idx];
endmodule : mld_motor_model

// ===== dv/tb_top.sv
// Self-checking bench for the motor lock and drive select block
`timescale 1ns/100ps
module tb_top;
  import mld_pkg::*;
  localparam int CAR = 1600;
  localparam int DEAD = 489;
  localparam int LOWC = CAR * 8 / 100;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic dir = 1'b0, spin = 1'b0, rev = 1'b0, opn = 1'b0, gnd = 1'b0, mode_b = 1'b0;
  logic [12:0] volt = 13'h0000;
  logic [7:0] duty = 8'h80;
  mld_phase_t hall, s_hi = 3'h0, s_lo = 3'h7;
  wire logic [2:0] hi, lo;
  logic tick, sine, lead, lck;
  logic [7:0] amp;
  int seed = 32'h0512;
  int mismatches = 0, check_count = 0, n, m, k, e;
  // Core clock, 4 ns period
  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  mld_motor_model motor (.core_clk_i(core_clk_i), .spin_i(spin), .rev_i(rev), .hall_o(hall), .tick_o(tick));
  mld_top #(.CARRIER_CYC(CAR), .REFRESH_CYC(50), .EDGE_WIN_CYC(200), .SLOW_CYC(400)) dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .hall_i(hall), .rotation_direction_select_i(dir),
    .speed_command_voltage_i(volt), .speed_mode_b_i(mode_b), .speed_duty_i(duty),
    .lock_timer_pin_tick_i(tick), .lock_timer_pin_open_i(opn), .lock_timer_pin_grounded_i(gnd),
    .sine_high_i(s_hi), .sine_low_i(s_lo),
    .phase_u_high_gate_o(hi[2]), .phase_v_high_gate_o(hi[1]), .phase_w_high_gate_o(hi[0]),
    .phase_u_low_gate_o(lo[2]), .phase_v_low_gate_o(lo[1]), .phase_w_low_gate_o(lo[0]),
    .drive_sine_o(sine), .lead_angle_en_o(lead), .lock_state_o(lck), .sine_amplitude_o(amp));
  // Compares a seen value with the expected one
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask : cyc
  function automatic logic watch(input int sel);
    return sel == 0 ? lck : (sel == 1 ? &lo : |hi);
  endfunction : watch
  // Counts cycles while the watched level holds, bounded against a hang
  task automatic span(input int sel, input logic want, output int c);
    c = 0;
    while (watch(sel) === want && c < 20000) begin
      cyc(1);
      c++;
    end
  endtask : span
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  // No phase may drive its high and low gate together
  always @(negedge core_clk_i) begin
    if (!sys_rst_i && (hi & lo) !== 3'h0) chk("shoot through", hi & lo, 3'h0);
  end
  // Watchdog
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    chk("gates after reset", {hi, lo}, 6'h00);
    // Start threshold in both speed modes: corners, then random levels
    // Lock detection stays on so a start above threshold runs the refresh
    gnd = 1'b0;
    for (m = 0; m < 2; m++) begin
      mode_b = m[0];
      e = m ? 200 : 2100;
      for (k = 0; k < 10; k++) begin
        volt = 13'h0000;
        cyc(4);
        volt = k < 2 ? 13'(e + k) : 13'({$random(seed)} % 4096);
        s_hi = 3'($random(seed));
        s_lo = ~s_hi;
        cyc(6);
        chk("refresh lows", lo, (int'(volt) > e) ? 3'h7 : 3'h0);
      end
    end
    // Open timer pin holds the lock with gates low
    volt = 13'h0fff;
    opn = 1'b1;
    cyc(4);
    chk("open hold", {lck, hi, lo}, 7'h40);
    // Stalled rotor: refresh, drive, then stop six times as long
    opn = 1'b0;
    gnd = 1'b0;
    cyc(3);
    span(0, 1'b0, n);
    chk("drive span", n + 3 >= 2040 && n + 3 <= 2070, 1'b1);
    cyc(6000);
    chk("stop gates", {hi, lo}, 6'h00);
    span(0, 1'b1, n);
    chk("stop span", n + 6000 >= 11990 && n + 6000 <= 12010, 1'b1);
    cyc(10);
    chk("refresh after stop", {hi, lo}, 6'h07);
    // Ordered Hall steps during drive clear the lock
    spin = 1'b1;
    cyc(3000);
    chk("lock cleared", lck, 1'b0);
    // Direction against Hall order picks the drive method
    for (k = 0; k < 4; k++) begin
      dir = k[0];
      rev = k[1];
      duty = 8'($random(seed));
      cyc(600);
      chk("sine select", sine, dir == rev);
      chk("lead enable", lead, 1'b1);
      chk("amplitude", amp, (dir == rev) ? duty : 8'h00);
    end
    // Stalled rotor with lock detection off: square carrier pattern
    spin = 1'b0;
    gnd = 1'b1;
    duty = 8'(20 + {$random(seed)} % 200);
    cyc(800);
    chk("square at stall", {sine, lead, lck}, 3'h0);
    span(1, 1'b1, n);
    span(1, 1'b0, n);
    span(1, 1'b1, n);
    chk("low pulse", n >= LOWC - 1 && n <= LOWC + 1, 1'b1);
    span(2, 1'b0, m);
    chk("dead time", m >= DEAD && m <= DEAD + 2, 1'b1);
    span(2, 1'b1, k);
    e = int'(duty) * ((CAR - LOWC - 2 * DEAD) / 255);
    chk("high on", k >= e - 2 && k <= e + 2, 1'b1);
    span(1, 1'b0, e);
    chk("carrier", n + m + k + e >= CAR - 1 && n + m + k + e <= CAR + 1, 1'b1);
    end_of_test();
  end
endmodule : tb_top

// ===== src/mld_carrier.sv
// Carrier counter with low-side bootstrap window and dead-timed high-side window
`timescale 1ns/100ps
`include "mld_params.svh"
module mld_carrier #(
  parameter int CARRIER_CYC = 13882
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Windows to the top
  mld_core_if.carrier pwm
);
  import mld_pkg::*;
  localparam longint DEAD_CYC = (`MLD_DEAD_OSC * `MLD_CLK_HZ + `MLD_OSC_HZ - 64'd1) / `MLD_OSC_HZ;
  localparam longint LOW_CYC = longint'(CARRIER_CYC) * `MLD_LOW_PCT / 64'd100;
  localparam longint STEP = (longint'(CARRIER_CYC) - LOW_CYC - 2 * DEAD_CYC) / 255;
  localparam logic [15:0] LAST_C = 16'(CARRIER_CYC - 1);
  localparam logic [15:0] LOW_C = 16'(LOW_CYC);
  localparam logic [15:0] HIGH0_C = 16'(LOW_CYC + DEAD_CYC);
  logic [15:0] cnt_reg;
  logic [15:0] on_cyc;
  logic low_win_reg;
  logic high_win_reg;

  // High-side on time scales with the speed duty, capped before the next dead time
  assign on_cyc = 16'(longint'(pwm.duty) * STEP); // RL17
  assign pwm.low_win = low_win_reg;
  assign pwm.high_win = high_win_reg;

  // Carrier period counter
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == LAST_C) begin
      cnt_reg <= 16'h0000; // RL15
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Windows; the high side starts a dead time after the low pulse ends
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_win_reg <= 1'b0;
      high_win_reg <= 1'b0;
    end else begin
      low_win_reg <= (cnt_reg < LOW_C); // RL16
      high_win_reg <= (cnt_reg >= HIGH0_C) && (cnt_reg < HIGH0_C + on_cyc); // RL14
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_CARRIER_WRAP: assert property (cnt_reg == LAST_C |=> cnt_reg == 16'h0000) // RL15
    else $error("carrier did not wrap");
  AST_LOW_SPAN: assert property (cnt_reg == LOW_C |=> !low_win_reg ##1 !low_win_reg) // RL16
    else $error("low pulse too long");
  AST_DEAD_GAP: assert property ($fell(low_win_reg) |-> !high_win_reg [*8]) // RL14
    else $error("no dead time after low pulse");
  AST_NO_OVERLAP: assert property (low_win_reg |-> !high_win_reg) // RL14
    else $error("high and low windows overlap");
endmodule : mld_carrier

// ===== src/mld_core_if.sv
// Internal carrier and lock-control bundle between the top and its two helpers
`timescale 1ns/100ps
interface mld_core_if;
  logic [7:0] duty;
  logic low_win;
  logic high_win;
  logic speed_above;
  logic hall_step;
  logic lock_tick;
  logic tr_open;
  logic tr_gnd;
  logic gate_en;
  logic refresh;
  logic locked;
  mld_pkg::mld_lock_st_t lock_st;
  modport carrier (input duty, output low_win, high_win);
  modport lock (input speed_above, hall_step, lock_tick, tr_open, tr_gnd,
                output gate_en, refresh, locked, lock_st);
  modport top (output duty, speed_above, hall_step, lock_tick, tr_open, tr_gnd,
               input low_win, high_win, gate_en, refresh, locked, lock_st);
endinterface : mld_core_if

// ===== src/mld_lock.sv
// Motor lock detection: drive/stop intermittent cycle, refresh and pin states
`timescale 1ns/100ps
`include "mld_params.svh"
module mld_lock #(
  parameter int REFRESH_CYC = 375000,
  parameter int EDGE_WIN_CYC = 41750000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Lock control to and from the top
  mld_core_if.lock lk
);
  import mld_pkg::*;
  mld_lock_st_t st_reg;
  logic tick_q_reg;
  logic [11:0] cnt_reg;
  logic [31:0] ref_cnt_reg;
  logic [31:0] gap_reg;
  logic seen_reg;
  logic tick_rise;
  logic rotating;
  logic guard;
  logic [11:0] term;

  assign tick_rise = lk.lock_tick && !tick_q_reg;
  assign guard = !lk.tr_open && !lk.tr_gnd && lk.speed_above;
  // Two Hall steps in order within the edge window mean the motor turns
  assign rotating = lk.hall_step && seen_reg && (gap_reg < 32'(EDGE_WIN_CYC - 1)); // RL3
  assign term = (st_reg == MLD_DRIVE) ? `MLD_DRIVE_TICKS - 12'd1 : `MLD_STOP_TICKS - 12'd1;
  assign lk.gate_en = ((st_reg == MLD_DRIVE) || (st_reg == MLD_RUN)) && lk.speed_above;
  assign lk.refresh = (st_reg == MLD_REFRESH);
  assign lk.locked = (st_reg == MLD_STOP) || (st_reg == MLD_OPEN);
  assign lk.lock_st = st_reg;

  // Lock state machine; pin states outrank the speed command
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= MLD_IDLE;
    end else if (lk.tr_open) begin
      st_reg <= MLD_OPEN; // RL7
    end else if (lk.tr_gnd) begin
      st_reg <= MLD_RUN; // RL8
    end else if (!lk.speed_above) begin
      st_reg <= MLD_IDLE; // RL4
    end else begin
      case (st_reg)
        MLD_IDLE: st_reg <= MLD_REFRESH;
        MLD_REFRESH: if (ref_cnt_reg == 32'(REFRESH_CYC - 1)) st_reg <= MLD_DRIVE; // RL5
        MLD_DRIVE: begin
          if (rotating) st_reg <= MLD_RUN; // RL3
          else if (tick_rise && cnt_reg == term) st_reg <= MLD_STOP; // RL1
        end
        MLD_STOP: if (tick_rise && cnt_reg == term) st_reg <= MLD_REFRESH; // RL2
        MLD_RUN: if (gap_reg == 32'(EDGE_WIN_CYC - 1)) st_reg <= MLD_DRIVE;
        default: st_reg <= MLD_IDLE;
      endcase
    end
  end

  // Interval counter on lock-timer oscillations, cleared outside drive and stop
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_q_reg <= 1'b0;
      cnt_reg <= 12'h000;
    end else begin
      tick_q_reg <= lk.lock_tick;
      if (st_reg != MLD_DRIVE && st_reg != MLD_STOP) cnt_reg <= 12'h000; // RL21
      else if (tick_rise) cnt_reg <= (cnt_reg == term) ? 12'h000 : cnt_reg + 12'h001; // RL6
    end
  end

  // Refresh timer and Hall edge gap timer
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_cnt_reg <= 32'h0000_0000;
      gap_reg <= 32'h0000_0000;
      seen_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= (st_reg == MLD_REFRESH) ? ref_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      if (lk.hall_step) begin
        gap_reg <= 32'h0000_0000;
        seen_reg <= 1'b1;
      end else if (gap_reg != 32'(EDGE_WIN_CYC - 1)) begin
        gap_reg <= gap_reg + 32'h0000_0001;
        seen_reg <= seen_reg && (st_reg != MLD_IDLE);
      end else begin
        seen_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_BELOW_CLEARS: assert property (!lk.tr_open && !lk.tr_gnd && !lk.speed_above |=> st_reg == MLD_IDLE) // RL4
    else $error("lock not cleared below threshold");
  AST_DRIVE_ENDS: assert property (guard && st_reg == MLD_DRIVE && tick_rise && cnt_reg == 12'd499 && !rotating
    |=> st_reg == MLD_STOP && cnt_reg == 12'h000) // RL6
    else $error("drive interval not 500 ticks");
  AST_STOP_ENDS: assert property (guard && st_reg == MLD_STOP && tick_rise && cnt_reg == 12'd2999
    |=> st_reg == MLD_REFRESH) // RL2
    else $error("stop interval not 3000 ticks");
  AST_REFRESH_LEN: assert property (guard && $rose(st_reg == MLD_REFRESH) |-> ref_cnt_reg == 32'h0000_0000) // RL5
    else $error("refresh timer not restarted");
  AST_ROTATE_CLEARS: assert property (guard && st_reg == MLD_DRIVE && rotating |=> st_reg == MLD_RUN) // RL3
    else $error("rotation did not clear lock");
  AST_GND_DISABLES: assert property (!lk.tr_open && lk.tr_gnd |=> st_reg == MLD_RUN) // RL8
    else $error("grounded pin did not disable detection");
endmodule : mld_lock

// ===== src/mld_params.svh
// Timing, threshold and count constants for the motor lock and drive select block
`ifndef MLD_PARAMS_SVH
`define MLD_PARAMS_SVH
// Core clock and internal oscillator rates in Hz
`define MLD_CLK_HZ 64'd250000000
`define MLD_OSC_HZ 64'd9220000
// Carrier is the oscillator divided by this
`define MLD_CARRIER_DIV 64'd512
// Dead time in oscillator cycles
`define MLD_DEAD_OSC 64'd18
// Low-side bootstrap pulse in percent of the carrier period
`define MLD_LOW_PCT 64'd8
// Lock drive and stop intervals in lock-timer oscillations
`define MLD_DRIVE_TICKS 12'd500
`define MLD_STOP_TICKS 12'd3000
// Refresh time, Hall edge window and slow-rotation period
`define MLD_REFRESH_US 64'd1500
`define MLD_EDGE_WIN_MS 64'd167
`define MLD_SLOW_MS 64'd1000
// Start thresholds of the speed command in mV, first and second speed mode
`define MLD_THR_A_MV 13'd2100
`define MLD_THR_B_MV 13'd200
`endif

// ===== src/mld_pkg.sv
// Types shared by the motor lock and drive select block
package mld_pkg;
  // Lock detection states
  typedef enum logic [2:0] {
    MLD_IDLE = 3'b000,
    MLD_DRIVE = 3'b001,
    MLD_STOP = 3'b010,
    MLD_REFRESH = 3'b011,
    MLD_RUN = 3'b100,
    MLD_OPEN = 3'b101
  } mld_lock_st_t;
  // One bit per phase: [2] U, [1] V, [0] W
  typedef logic [2:0] mld_phase_t;
endpackage : mld_pkg

// ===== src/mld_top.sv
// Top of the motor lock and drive select block: Hall tracking, drive choice, gates
//
// What this block does
// RL1: Gates go off when speed is above start yet motor stays stopped.
// RL2: Locked operation alternates drive and stop intervals, stop six times drive.
// RL3: Two ordered Hall edges under 0.167 s apart in drive clear the lock.
// RL4: Speed command at or below start threshold resets lock detection.
// RL5: After each stop interval a 1.5 ms refresh runs before commutation.
// RL6: Drive interval is 500 lock-timer oscillations, stop is 3000.
// RL7: Open lock-timer pin holds the lock state with gates low.
// RL8: Grounded lock-timer pin disables lock detection.
// RL9: Direction input high means reverse rotation, low means forward.
// RL10: Direction low with inverted Hall order gives square drive, else sine.
// RL11: Direction high with normal Hall order gives square drive, else sine.
// RL12: Lead angle control is enabled only at Hall frequency of 1 Hz or more.
// RL13: In square drive every low side pulses each carrier period for bootstrap.
// RL14: High sides turn off at the low pulse, with 18 oscillator cycles dead time.
// RL15: Carrier period is 512 oscillator cycles.
// RL16: Low-side pulse lasts 8 percent of the carrier, independent of speed.
// RL17: Square drive sets high-side on time from the speed command.
// RL18: Square drive below 1 Hz or when rotation opposes the set direction.
// RL19: Sine drive at 1 Hz or more with matching rotation direction.
// RL20: Sine drive scales modulation amplitude with the speed command.
// RL21: Lock intervals counted on lock-timer ticks, restarted per interval.
`timescale 1ns/100ps
`include "mld_params.svh"
module mld_top #(
  parameter int CARRIER_CYC = int'(`MLD_CARRIER_DIV * `MLD_CLK_HZ / `MLD_OSC_HZ),
  parameter int REFRESH_CYC = int'((`MLD_REFRESH_US * `MLD_CLK_HZ + 64'd999999) / 64'd1000000),
  parameter int EDGE_WIN_CYC = int'(`MLD_EDGE_WIN_MS * `MLD_CLK_HZ / 64'd1000),
  parameter int SLOW_CYC = int'(`MLD_SLOW_MS * `MLD_CLK_HZ / 64'd1000)
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Hall sensors and direction
  input wire mld_pkg::mld_phase_t hall_i,
  input wire logic rotation_direction_select_i,
  // Speed command
  input wire logic [12:0] speed_command_voltage_i,
  input wire logic speed_mode_b_i,
  input wire logic [7:0] speed_duty_i,
  // Lock-timer pin
  input wire logic lock_timer_pin_tick_i,
  input wire logic lock_timer_pin_open_i,
  input wire logic lock_timer_pin_grounded_i,
  // Sine modulator gate requests
  input wire mld_pkg::mld_phase_t sine_high_i,
  input wire mld_pkg::mld_phase_t sine_low_i,
  // Gate outputs to the power stage
  output logic phase_u_high_gate_o,
  output logic phase_v_high_gate_o,
  output logic phase_w_high_gate_o,
  output logic phase_u_low_gate_o,
  output logic phase_v_low_gate_o,
  output logic phase_w_low_gate_o,
  // Status
  output logic drive_sine_o,
  output logic lead_angle_en_o,
  output logic lock_state_o,
  output logic [7:0] sine_amplitude_o
);
  import mld_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  mld_core_if core ();
  mld_phase_t hall_q_reg;
  mld_phase_t gate_hi_reg;
  mld_phase_t gate_lo_reg;
  mld_phase_t hi_next;
  mld_phase_t lo_next;
  logic [5:0] sq;
  logic step_fwd;
  logic step_rev;
  logic u_fall;
  logic hall_step_reg;
  logic rot_rev_reg;
  logic dir_reg;
  logic slow_reg;
  logic [31:0] per_cnt_reg;
  logic speed_above_reg;
  logic [7:0] duty_reg;
  logic drive_sine_reg;
  logic lead_reg;
  logic lock_reg;
  logic [7:0] amp_reg;
  logic [12:0] thr;

  // ************************************************************
  // Functions
  // ************************************************************
  // Next Hall code in forward order
  function automatic mld_phase_t fwd_next(input mld_phase_t h);
    case (h)
      3'b100: fwd_next = 3'b110;
      3'b110: fwd_next = 3'b010;
      3'b010: fwd_next = 3'b011;
      3'b011: fwd_next = 3'b001;
      3'b001: fwd_next = 3'b101;
      3'b101: fwd_next = 3'b100;
      default: fwd_next = h;
    endcase
  endfunction : fwd_next

  // Square-wave phases {high, low} for a Hall code; reverse swaps the sides
  function automatic logic [5:0] sq_phases(input mld_phase_t h, input logic rev);
    logic [5:0] p;
    case (h)
      3'b100: p = 6'h22;
      3'b110: p = 6'h21;
      3'b010: p = 6'h11;
      3'b011: p = 6'h14;
      3'b001: p = 6'h0c;
      3'b101: p = 6'h0a;
      default: p = 6'h00;
    endcase
    sq_phases = rev ? {p[2:0], p[5:3]} : p;
  endfunction : sq_phases

  // ************************************************************
  // Helpers
  // ************************************************************
  mld_carrier #(
    .CARRIER_CYC(CARRIER_CYC)
  ) u_carrier (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .pwm(core.carrier)
  );

  mld_lock #(
    .REFRESH_CYC(REFRESH_CYC),
    .EDGE_WIN_CYC(EDGE_WIN_CYC)
  ) u_lock (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .lk(core.lock)
  );

  // Helper inputs
  assign core.duty = duty_reg;
  assign core.speed_above = speed_above_reg;
  assign core.hall_step = hall_step_reg;
  assign core.lock_tick = lock_timer_pin_tick_i;
  assign core.tr_open = lock_timer_pin_open_i;
  assign core.tr_gnd = lock_timer_pin_grounded_i;

  // ************************************************************
  // Hall tracking
  // ************************************************************
  // Step detection in either order; a code that is neither is ignored
  assign step_fwd = (hall_i != hall_q_reg) && (hall_i == fwd_next(hall_q_reg));
  assign step_rev = (hall_i != hall_q_reg) && (hall_q_reg == fwd_next(hall_i));
  assign u_fall = hall_q_reg[2] && !hall_i[2];

  // Hall history, step pulse and detected rotation
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hall_q_reg <= 3'h0;
      hall_step_reg <= 1'b0;
      rot_rev_reg <= 1'b0;
    end else begin
      hall_q_reg <= hall_i;
      hall_step_reg <= step_fwd || step_rev;
      if (step_rev) rot_rev_reg <= 1'b1;
      else if (step_fwd) rot_rev_reg <= 1'b0;
    end
  end

  // Hall period on U falling edges; slow means under 1 Hz
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_cnt_reg <= 32'h0000_0000;
      slow_reg <= 1'b1;
    end else if (u_fall) begin
      per_cnt_reg <= 32'h0000_0000;
      slow_reg <= (per_cnt_reg >= 32'(SLOW_CYC - 1));
    end else if (per_cnt_reg != 32'(SLOW_CYC - 1)) begin
      per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
    end else begin
      slow_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Speed command and drive choice
  // ************************************************************
  // Start threshold depends on speed mode
  assign thr = speed_mode_b_i ? `MLD_THR_B_MV : `MLD_THR_A_MV;

  // Speed level, direction and drive method
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      speed_above_reg <= 1'b0;
      duty_reg <= 8'h00;
      dir_reg <= 1'b0;
      drive_sine_reg <= 1'b0;
      lead_reg <= 1'b0;
    end else begin
      speed_above_reg <= (speed_command_voltage_i > thr); // RL1
      duty_reg <= speed_duty_i; // RL17
      dir_reg <= rotation_direction_select_i; // RL9
      drive_sine_reg <= !slow_reg && (rot_rev_reg == dir_reg); // RL10 RL11 RL18 RL19
      lead_reg <= !slow_reg; // RL12
    end
  end

  // ************************************************************
  // Gate generation
  // ************************************************************
  // Off when blocked, lows on in refresh, else sine requests or square pattern
  always_comb begin
    sq = sq_phases(hall_q_reg, dir_reg); // RL9
    hi_next = 3'h0;
    lo_next = 3'h0;
    if (!core.gate_en) begin
      if (core.refresh) lo_next = 3'h7; // RL5
    end else if (drive_sine_reg) begin
      hi_next = sine_high_i;
      lo_next = sine_low_i;
    end else begin
      hi_next = sq[5:3] & {3{core.high_win}}; // RL14
      lo_next = sq[2:0] | {3{core.low_win}}; // RL13
    end
  end

  // Gate and status output flops
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_hi_reg <= 3'h0;
      gate_lo_reg <= 3'h0;
      lock_reg <= 1'b0;
      amp_reg <= 8'h00;
    end else begin
      gate_hi_reg <= hi_next; // RL1 RL7
      gate_lo_reg <= lo_next;
      lock_reg <= core.locked;
      amp_reg <= drive_sine_reg ? duty_reg : 8'h00; // RL20
    end
  end

  // Outputs straight from flops
  assign phase_u_high_gate_o = gate_hi_reg[2];
  assign phase_v_high_gate_o = gate_hi_reg[1];
  assign phase_w_high_gate_o = gate_hi_reg[0];
  assign phase_u_low_gate_o = gate_lo_reg[2];
  assign phase_v_low_gate_o = gate_lo_reg[1];
  assign phase_w_low_gate_o = gate_lo_reg[0];
  assign drive_sine_o = drive_sine_reg;
  assign lead_angle_en_o = lead_reg;
  assign lock_state_o = lock_reg;
  assign sine_amplitude_o = amp_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_open_held;
    lock_timer_pin_open_i ##1 lock_timer_pin_open_i;
  endsequence
  sequence s_gates_off;
    gate_hi_reg == 3'h0 && gate_lo_reg == 3'h0;
  endsequence
  sequence s_square_pulse;
    core.gate_en && !drive_sine_reg && core.low_win;
  endsequence

  AST_STOP_OFF: assert property (core.lock_st == MLD_STOP |=> s_gates_off) // RL1
    else $error("gates active in stop interval");
  AST_OPEN_OFF: assert property (s_open_held |=> s_gates_off and lock_reg) // RL7
    else $error("open pin did not hold gates low");
  AST_BOOT_PULSE: assert property (s_square_pulse |=> gate_lo_reg == 3'h7) // RL13
    else $error("low sides not pulsed in carrier");
  AST_HIGH_OFF_PULSE: assert property (s_square_pulse |=> gate_hi_reg == 3'h0) // RL14
    else $error("high side on during low pulse");
  AST_SLOW_SQUARE: assert property (slow_reg |=> !drive_sine_o && !lead_angle_en_o) // RL18
    else $error("sine or lead angle while slow");
  AST_OPPOSE_SQUARE: assert property (rot_rev_reg != dir_reg |=> !drive_sine_o) // RL10
    else $error("sine drive with opposed rotation");
  AST_MATCH_SINE: assert property (!slow_reg && rot_rev_reg == dir_reg |=> drive_sine_o && lead_angle_en_o) // RL19
    else $error("no sine drive at speed with matching rotation");
  AST_SINE_AMP: assert property (drive_sine_reg |=> sine_amplitude_o == $past(duty_reg)) // RL20
    else $error("sine amplitude not following speed");
endmodule : mld_top
